// >>> rtl/wkw_pkg.sv
// Function
// - run only while enable set; strap sets reset
// - period is time-out, at least 0x100
// - load counter on enable and valid service
// - counter decrements on internal rc clock
// - locks make configuration registers read-only
// - hard lock stays set until reset
// - 0xC520 then 0xD928 clears soft lock
// - unlock detector ignores interleaved service writes
// - unlock accepted anytime, even when disabled
// - fixed service pair 0xA602 then 0xB480
// - keyed service: key = 17*key+3 mod 65536
// - register accesses complete without wait states
// - service and config acted on quickly
// - window mode: service valid below window value
// - closed-window service while enabled gives bus error or reset
// - window opens within synchronisation lag
// - without interrupt-then-reset, time-out resets immediately
// - with it: interrupt, reload, second time-out resets
// - write 1 clears time-out flag and interrupt
// - counter view shows count only when disabled
// - debug freeze halts counter in debug mode
// - window start register resets to zero
package wkw_pkg;

    localparam int unsigned  CNT_W         = 32;
    localparam int unsigned  CODE_W        = 16;

    localparam logic [31:0]  MIN_PERIOD    = 32'h0000_0100;
    localparam logic [31:0]  ONE_COUNT     = 32'h0000_0001;
    localparam logic [31:0]  ZERO_COUNT    = 32'h0000_0000;
    localparam logic [31:0]  TIMEOUT_RST   = 32'h0001_0000;
    localparam logic [31:0]  WINDOW_RST    = 32'h0000_0000;
    localparam logic [15:0]  KEY_RST       = 16'h0000;

    localparam logic [15:0]  SVC_FIRST     = 16'hA602;
    localparam logic [15:0]  SVC_SECOND    = 16'hB480;
    localparam logic [15:0]  UNLOCK_FIRST  = 16'hC520;
    localparam logic [15:0]  UNLOCK_SECOND = 16'hD928;
    localparam logic [15:0]  KEY_MULT      = 16'h0011;
    localparam logic [15:0]  KEY_ADD       = 16'h0003;

    typedef struct packed {
        logic hard_lock;
        logic soft_lock;
        logic keyed_mode;
        logic window_mode;
        logic invalid_access_reset;
        logic interrupt_then_reset;
        logic debug_freeze;
        logic enable;
    } wkw_ctrl_t;

    localparam wkw_ctrl_t    CTRL_RST      = 8'h00;

    typedef struct packed {
        logic timeout_flag;
        logic irq;
        logic sys_reset;
        logic bus_error;
    } wkw_status_t;

    typedef enum logic [0:0] {
        SVC_IDLE = 1'b0,
        SVC_HALF = 1'b1
    } wkw_seq_t;

    function automatic logic [15:0] next_key(input logic [15:0] key);
        next_key = 16'(key * KEY_MULT + KEY_ADD);
    endfunction : next_key

endpackage : wkw_pkg

// >>> rtl/wkw_pin_filter.sv
`timescale 1ns/100ps
module wkw_pin_filter
(
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic pin,
    output logic      level
);

    logic stage1_ff;
    logic stage2_ff;
    logic stage3_ff;
    logic level_ff;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            stage1_ff <= 1'b0;
            stage2_ff <= 1'b0;
            stage3_ff <= 1'b0;
        end
        else
        begin
            stage1_ff <= pin;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
        end
    end

    // a change is believed only once two later stages agree
    always_ff @(posedge clk)
    begin
        if (srst)
            level_ff <= 1'b0;
        else if (stage2_ff == stage3_ff)
            level_ff <= stage3_ff;
    end

    assign level = level_ff;

endmodule : wkw_pin_filter

// >>> rtl/wkw_top.sv
`timescale 1ns/100ps
module wkw_top
#(
    parameter logic [31:0] TIMEOUT_RESET = wkw_pkg::TIMEOUT_RST
)
(
    input  wire logic               clk,
    input  wire logic               srst,
    input  wire logic               enable_strap,
    input  wire logic               debug_mode,
    input  wire logic               internal_rc_clock,
    input  wire logic               ctrl_wr,
    input  wire wkw_pkg::wkw_ctrl_t ctrl_wdata,
    input  wire logic               timeout_wr,
    input  wire logic [31:0]        timeout_wdata,
    input  wire logic               window_wr,
    input  wire logic [31:0]        window_wdata,
    input  wire logic               key_wr,
    input  wire logic [15:0]        key_wdata,
    input  wire logic               service_wr,
    input  wire logic [15:0]        service_wdata,
    input  wire logic               irq_flag_wr,
    input  wire logic               irq_flag_wdata,
    output wkw_pkg::wkw_ctrl_t      ctrl_rdata,
    output logic [31:0]             timeout_rdata,
    output logic [31:0]             window_rdata,
    output logic [15:0]             key_rdata,
    output logic [31:0]             counter_view,
    output wkw_pkg::wkw_status_t    status,
    output logic                    access_ready
);

    wkw_pkg::wkw_ctrl_t   ctrl_ff;
    logic [31:0]          timeout_ff;
    logic [31:0]          window_ff;
    logic [15:0]          key_ff;
    logic [31:0]          cnt_ff;
    logic [31:0]          view_ff;
    logic                 enable_prev_ff;
    logic                 rc_prev_ff;
    logic                 first_timeout_ff;
    logic                 flag_ff;
    logic                 reset_req_ff;
    logic                 bus_error_ff;
    wkw_pkg::wkw_seq_t    svc_state_ff;
    wkw_pkg::wkw_seq_t    unlock_state_ff;

    logic                 rc_level;
    logic                 rc_tick;
    logic                 count_en;
    logic                 count_tick;
    logic                 timeout_evt;
    logic                 locked;
    logic [31:0]          eff_period;
    logic                 window_open;
    logic                 is_unlock_code;
    logic                 svc_wr_ok;
    logic                 svc_invalid;
    logic [15:0]          exp_key;
    logic                 key_hit;
    logic                 fixed_hit_first;
    logic                 fixed_hit_second;
    logic                 svc_done;
    logic                 unlock_done;
    logic                 enable_rise;
    logic                 load_cnt;
    logic                 first_timeout;
    logic                 final_timeout;

    // rc clock comes in as a pin and is sampled, so the count rate must stay
    // well below half of clk
    wkw_pin_filter u_rc_filter
    (
        .clk   (clk),
        .srst  (srst),
        .pin   (internal_rc_clock),
        .level (rc_level)
    );

    always_ff @(posedge clk)
    begin
        if (srst)
            rc_prev_ff <= 1'b0;
        else
            rc_prev_ff <= rc_level;
    end

    assign rc_tick    = rc_level & ~rc_prev_ff;
    assign count_en   = ctrl_ff.enable & ~(debug_mode & ctrl_ff.debug_freeze);
    assign count_tick = rc_tick & count_en;
    assign timeout_evt = count_tick & (cnt_ff <= wkw_pkg::ONE_COUNT);

    assign locked = ctrl_ff.soft_lock | ctrl_ff.hard_lock;

    assign eff_period = (timeout_ff < wkw_pkg::MIN_PERIOD) ?
                        wkw_pkg::MIN_PERIOD : timeout_ff;

    // compare against the live counter, so the window opens on the first
    // clk after the crossing tick
    assign window_open = ~ctrl_ff.window_mode | (cnt_ff < window_ff);

    assign is_unlock_code = (service_wdata == wkw_pkg::UNLOCK_FIRST) |
                            (service_wdata == wkw_pkg::UNLOCK_SECOND);

    assign svc_wr_ok   = service_wr & ~is_unlock_code & window_open;
    assign svc_invalid = service_wr & ~is_unlock_code & ~window_open
                         & ctrl_ff.enable;

    assign exp_key          = wkw_pkg::next_key(key_ff);
    assign key_hit          = ctrl_ff.keyed_mode & (service_wdata == exp_key);
    assign fixed_hit_first  = ~ctrl_ff.keyed_mode &
                              (service_wdata == wkw_pkg::SVC_FIRST);
    assign fixed_hit_second = ~ctrl_ff.keyed_mode &
                              (service_wdata == wkw_pkg::SVC_SECOND);

    assign svc_done = svc_wr_ok & (svc_state_ff == wkw_pkg::SVC_HALF) &
                      (key_hit | fixed_hit_second);

    assign unlock_done = service_wr & (unlock_state_ff == wkw_pkg::SVC_HALF) &
                         (service_wdata == wkw_pkg::UNLOCK_SECOND);

    assign enable_rise   = ctrl_ff.enable & ~enable_prev_ff;
    assign first_timeout = timeout_evt & ctrl_ff.interrupt_then_reset
                           & ~first_timeout_ff;
    assign final_timeout = timeout_evt & ~first_timeout;
    assign load_cnt      = enable_rise | svc_done | first_timeout;

    // service sequence tracker
    always_ff @(posedge clk)
    begin
        if (srst)
            svc_state_ff <= wkw_pkg::SVC_IDLE;
        else if (svc_wr_ok)
        begin
            case (svc_state_ff)
                wkw_pkg::SVC_IDLE:
                begin
                    if (key_hit | fixed_hit_first)
                        svc_state_ff <= wkw_pkg::SVC_HALF;
                end
                wkw_pkg::SVC_HALF:
                begin
                    if (fixed_hit_first)
                        svc_state_ff <= wkw_pkg::SVC_HALF;
                    else
                        svc_state_ff <= wkw_pkg::SVC_IDLE;
                end
                default:
                    svc_state_ff <= wkw_pkg::SVC_IDLE;
            endcase
        end
    end

    // unlock tracker; service-pattern writes pass without disturbing it
    always_ff @(posedge clk)
    begin
        if (srst)
            unlock_state_ff <= wkw_pkg::SVC_IDLE;
        else if (service_wr & is_unlock_code)
        begin
            case (unlock_state_ff)
                wkw_pkg::SVC_IDLE:
                begin
                    if (service_wdata == wkw_pkg::UNLOCK_FIRST)
                        unlock_state_ff <= wkw_pkg::SVC_HALF;
                end
                wkw_pkg::SVC_HALF:
                begin
                    if (service_wdata == wkw_pkg::UNLOCK_SECOND)
                        unlock_state_ff <= wkw_pkg::SVC_IDLE;
                end
                default:
                    unlock_state_ff <= wkw_pkg::SVC_IDLE;
            endcase
        end
    end

    // control register; strap is caught by the synchronous reset
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrl_ff        <= wkw_pkg::CTRL_RST;
            ctrl_ff.enable <= enable_strap;
        end
        else
        begin
            if (ctrl_wr & ~locked)
                ctrl_ff <= ctrl_wdata;
            if (unlock_done)
                ctrl_ff.soft_lock <= 1'b0;
            if (ctrl_ff.hard_lock)
                ctrl_ff.hard_lock <= 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            timeout_ff <= TIMEOUT_RESET;
        else if (timeout_wr & ~locked)
            timeout_ff <= timeout_wdata;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            window_ff <= wkw_pkg::WINDOW_RST;
        else if (window_wr & ~locked)
            window_ff <= window_wdata;
    end

    // the key advances on every accepted key, the software write on lock-free
    always_ff @(posedge clk)
    begin
        if (srst)
            key_ff <= wkw_pkg::KEY_RST;
        else if (svc_wr_ok & key_hit)
            key_ff <= exp_key;
        else if (key_wr & ~locked)
            key_ff <= key_wdata;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            enable_prev_ff <= 1'b0;
        else
            enable_prev_ff <= ctrl_ff.enable;
    end

    // down counter; after a final time-out it rests at zero until reset or the next load (enable rise or valid service)
    always_ff @(posedge clk)
    begin
        if (srst)
            cnt_ff <= wkw_pkg::ZERO_COUNT;
        else if (load_cnt)
            cnt_ff <= eff_period;
        else if (count_tick & (cnt_ff != wkw_pkg::ZERO_COUNT))
            cnt_ff <= cnt_ff - wkw_pkg::ONE_COUNT;
    end

    // remembers that the interrupt stage has already been used
    always_ff @(posedge clk)
    begin
        if (srst)
            first_timeout_ff <= 1'b0;
        else if (first_timeout)
            first_timeout_ff <= 1'b1;
        else if (svc_done | ~ctrl_ff.enable)
            first_timeout_ff <= 1'b0;
    end

    // a new time-out wins over a clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (srst)
            flag_ff <= 1'b0;
        else if (first_timeout)
            flag_ff <= 1'b1;
        else if (irq_flag_wr & irq_flag_wdata)
            flag_ff <= 1'b0;
    end

    // held until the system reset comes back as srst
    always_ff @(posedge clk)
    begin
        if (srst)
            reset_req_ff <= 1'b0;
        else if (final_timeout)
            reset_req_ff <= 1'b1;
        else if (svc_invalid & ctrl_ff.invalid_access_reset)
            reset_req_ff <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            bus_error_ff <= 1'b0;
        else
            bus_error_ff <= svc_invalid & ~ctrl_ff.invalid_access_reset;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            view_ff <= wkw_pkg::ZERO_COUNT;
        else if (ctrl_ff.enable)
            view_ff <= wkw_pkg::ZERO_COUNT;
        else
            view_ff <= cnt_ff;
    end

    assign ctrl_rdata          = ctrl_ff;
    assign timeout_rdata       = timeout_ff;
    assign window_rdata        = window_ff;
    assign key_rdata           = key_ff;
    assign counter_view        = view_ff;
    assign status.timeout_flag = flag_ff;
    assign status.irq          = flag_ff;
    assign status.sys_reset    = reset_req_ff;
    assign status.bus_error    = bus_error_ff;
    assign access_ready        = 1'b1;

endmodule : wkw_top

// >>> verif/wkw_checker.sv
`timescale 1ns/100ps
module wkw_checker
(
    input wire logic                 clk,
    input wire logic                 srst,
    input wire logic                 ctrl_wr,
    input wire logic                 timeout_wr,
    input wire logic [31:0]          timeout_wdata,
    input wire logic                 service_wr,
    input wire logic [15:0]          service_wdata,
    input wire logic                 irq_flag_wr,
    input wire logic                 irq_flag_wdata,
    input wire wkw_pkg::wkw_ctrl_t   ctrl_rdata,
    input wire logic [31:0]          timeout_rdata,
    input wire logic [31:0]          counter_view,
    input wire wkw_pkg::wkw_status_t status,
    input wire logic                 access_ready
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    logic lk;
    assign lk = ctrl_rdata.soft_lock | ctrl_rdata.hard_lock;

    sequence s_unlock;
        service_wr && service_wdata == wkw_pkg::UNLOCK_FIRST
        ##[1:4] service_wr && service_wdata == wkw_pkg::UNLOCK_SECOND && !ctrl_wr;
    endsequence

    a_no_wait_states: assert property (access_ready)
        else $error("access_ready dropped");
    a_lock_refuses_write: assert property (lk && timeout_wr |=> $stable(timeout_rdata))
        else $error("time-out changed while locked");
    a_timeout_write_taken: assert property (!lk && timeout_wr |=> timeout_rdata == $past(timeout_wdata))
        else $error("time-out write lost");
    a_hard_lock_sticky: assert property (ctrl_rdata.hard_lock |=> ctrl_rdata.hard_lock)
        else $error("hard lock cleared without reset");
    a_unlock_pair_clears: assert property (s_unlock |=> !ctrl_rdata.soft_lock)
        else $error("unlock pair did not clear soft lock");
    a_flag_write_zero: assert property (status.timeout_flag && irq_flag_wr && !irq_flag_wdata |=> status.timeout_flag)
        else $error("writing zero cleared the flag");
    a_irq_follows_flag: assert property (status.irq == status.timeout_flag)
        else $error("irq and flag disagree");
    a_flag_needs_itr: assert property ($rose(status.timeout_flag) |->
        ctrl_rdata.interrupt_then_reset && !status.sys_reset)
        else $error("time-out flag set outside interrupt-then-reset mode");
    a_sys_reset_sticky: assert property (status.sys_reset |=> status.sys_reset)
        else $error("system reset released");
    a_view_zero_enabled: assert property (ctrl_rdata.enable [*8] |-> counter_view == wkw_pkg::ZERO_COUNT)
        else $error("counter view not zero while enabled");
    a_bus_error_cause: assert property (status.bus_error |-> ctrl_rdata.window_mode && ($past(service_wr) || $past(service_wr, 2)))
        else $error("bus error without closed-window service");
endmodule : wkw_checker

bind wkw_top wkw_checker u_chk
(
    .clk(clk), .srst(srst), .ctrl_wr(ctrl_wr), .timeout_wr(timeout_wr),
    .timeout_wdata(timeout_wdata), .service_wr(service_wr), .service_wdata(service_wdata),
    .irq_flag_wr(irq_flag_wr), .irq_flag_wdata(irq_flag_wdata), .ctrl_rdata(ctrl_rdata),
    .timeout_rdata(timeout_rdata), .counter_view(counter_view), .status(status),
    .access_ready(access_ready)
);

// >>> verif/wkw_top_tb.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin bad_count++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module wkw_top_tb;
    localparam logic [31:0] TO_RST = 32'h0000_0120;
    logic                 clk   = 1'b0;
    logic                 srst  = 1'b1;
    logic                 strap = 1'b1;
    logic                 dbg   = 1'b0;
    logic                 rc    = 1'b0;
    logic [5:0]           wr    = 6'h00;
    logic [31:0]          wd    = 32'h0000_0000;
    wkw_pkg::wkw_ctrl_t   c     = '0;
    wkw_pkg::wkw_ctrl_t   ctrl_rdata;
    wkw_pkg::wkw_status_t status;
    logic [31:0]          timeout_rdata;
    logic [31:0]          window_rdata;
    logic [31:0]          counter_view;
    logic [15:0]          key_rdata;
    logic                 access_ready;
    int                   bad_count = 0;
    int                   n_checks  = 0;
    int                   cyc       = 0;

    wkw_top #(.TIMEOUT_RESET(TO_RST)) dut
    (
        .clk(clk), .srst(srst), .enable_strap(strap), .debug_mode(dbg),
        .internal_rc_clock(rc), .ctrl_wr(wr[0]), .ctrl_wdata(wd[7:0]),
        .timeout_wr(wr[1]), .timeout_wdata(wd), .window_wr(wr[2]), .window_wdata(wd),
        .key_wr(wr[3]), .key_wdata(wd[15:0]), .service_wr(wr[4]), .service_wdata(wd[15:0]),
        .irq_flag_wr(wr[5]), .irq_flag_wdata(wd[0]), .ctrl_rdata(ctrl_rdata),
        .timeout_rdata(timeout_rdata), .window_rdata(window_rdata), .key_rdata(key_rdata),
        .counter_view(counter_view), .status(status), .access_ready(access_ready)
    );

    initial
    begin
        forever #50 clk = ~clk;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            bad_count++;
            final_report();
        end
    end

    // k: 0 ctrl, 1 time-out, 2 window, 3 key, 4 service, 5 flag
    task automatic w(input int k, input logic [31:0] d);
        wd = d;
        wr[k] = 1'b1;
        @(posedge clk);
        #1;
        wr = 6'h00;
        // one idle edge keeps the next strobe out of this time step
        @(posedge clk);
        #1;
    endtask : w

    // high and low of 4 clk each keep every edge visible through the pin filter
    task automatic ticks(input int n);
        repeat (n)
        begin
            rc = 1'b1;
            repeat (4) @(posedge clk);
            #1;
            rc = 1'b0;
            repeat (4) @(posedge clk);
            #1;
        end
    endtask : ticks

    task automatic rst();
        strap = 1'b0;
        srst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        srst = 1'b0;
    endtask : rst

    task automatic en(input logic [31:0] to);
        w(1, to);
        c.enable = 1'b1;
        w(0, c);
        repeat (4) @(posedge clk);
        #1;
    endtask : en

    // the view is only live while disabled, so every count check disables first
    task automatic vchk(input string n, input logic [31:0] e);
        c.enable = 1'b0;
        w(0, c);
        repeat (12) @(posedge clk);
        #1;
        `CHK(n, e, counter_view)
    endtask : vchk

    task automatic t_reset();
        repeat (4) @(posedge clk);
        #1;
        `CHK("ctrl", 8'h01, ctrl_rdata)
        `CHK("timeout", TO_RST, timeout_rdata)
        `CHK("window", 32'h0000_0000, window_rdata)
        `CHK("key", 16'h0000, key_rdata)
        `CHK("status", 4'h0, status)
        `CHK("ready", 1'b1, access_ready)
        vchk("strap load", TO_RST);
    endtask : t_reset

    task automatic t_floor();
        logic [31:0] tv [3];
        tv = '{32'h0000_00FF, 32'h0000_0100, 32'h0000_0155};
        foreach (tv[i])
        begin
            en(tv[i]);
            vchk("floor", (tv[i] < 32'h0000_0100) ? 32'h0000_0100 : tv[i]);
        end
    endtask : t_floor

    task automatic t_count();
        en(32'h0000_0100);
        ticks(10);
        `CHK("view enabled", 32'h0000_0000, counter_view)
        vchk("count", 32'h0000_00F6);
        c.debug_freeze = 1'b1;
        en(32'h0000_0100);
        dbg = 1'b1;
        ticks(6);
        dbg = 1'b0;
        ticks(2);
        vchk("frozen", 32'h0000_00FE);
        c.debug_freeze = 1'b0;
        en(32'h0000_0100);
        dbg = 1'b1;
        ticks(3);
        dbg = 1'b0;
        vchk("not frozen", 32'h0000_00FD);
    endtask : t_count

    task automatic t_service();
        en(32'h0000_0100);
        ticks(10);
        w(4, 32'h0000_A602);
        w(4, 32'h0000_C520);
        w(4, 32'h0000_B480);
        vchk("service", 32'h0000_0100);
        en(32'h0000_0100);
        ticks(5);
        w(4, 32'h0000_A602);
        w(4, 32'h0000_1234);
        w(4, 32'h0000_B480);
        vchk("broken pair", 32'h0000_00FB);
    endtask : t_service

    task automatic t_keyed();
        logic [15:0] k1;
        logic [15:0] k2;
        k1 = 16'h0100 * 16'h0011 + 16'h0003;
        k2 = k1 * 16'h0011 + 16'h0003;
        c.keyed_mode = 1'b1;
        w(3, 32'h0000_0100);
        en(32'h0000_0100);
        ticks(5);
        w(4, {16'h0000, k1});
        w(4, {16'h0000, k2});
        `CHK("key next", k2, key_rdata)
        vchk("keyed", 32'h0000_0100);
    endtask : t_keyed

    task automatic t_lock();
        c = '0;
        w(1, 32'h0000_0180);
        // the service scenario left the unlock tracker armed; spend it first
        w(4, 32'h0000_D928);
        c.soft_lock = 1'b1;
        w(0, c);
        w(1, 32'h0000_0200);
        `CHK("locked to", 32'h0000_0180, timeout_rdata)
        w(4, 32'h0000_D928);
        `CHK("lone second", 1'b1, ctrl_rdata.soft_lock)
        w(4, 32'h0000_C520);
        w(4, 32'h0000_A602);
        w(4, 32'h0000_D928);
        @(posedge clk);
        #1;
        `CHK("unlocked", 1'b0, ctrl_rdata.soft_lock)
        c = '0;
        c.hard_lock = 1'b1;
        w(0, c);
        c = '0;
        w(0, c);
        w(2, 32'h0000_0040);
        `CHK("hard kept", 1'b1, ctrl_rdata.hard_lock)
        `CHK("hard window", 32'h0000_0000, window_rdata)
        rst();
    endtask : t_lock

    task automatic t_tmo();
        en(32'h0000_0100);
        ticks(255);
        `CHK("early reset", 1'b0, status.sys_reset)
        ticks(1);
        `CHK("expiry reset", 1'b1, status.sys_reset)
        rst();
        c.interrupt_then_reset = 1'b1;
        en(32'h0000_0100);
        ticks(256);
        `CHK("first expiry", 3'b110, {status.timeout_flag, status.irq, status.sys_reset})
        w(5, 32'h0000_0000);
        `CHK("flag kept", 1'b1, status.timeout_flag)
        w(5, 32'h0000_0001);
        @(posedge clk);
        #1;
        `CHK("flag cleared", 2'b00, {status.timeout_flag, status.irq})
        ticks(255);
        `CHK("second early", 1'b0, status.sys_reset)
        ticks(1);
        `CHK("second expiry", 1'b1, status.sys_reset)
        rst();
    endtask : t_tmo

    task automatic t_window();
        logic be;
        c = '0;
        c.window_mode = 1'b1;
        w(2, 32'h0000_0080);
        en(32'h0000_0100);
        ticks(2);
        // driven by hand so the one-cycle error pulse is seen right after its edge
        wd = 32'h0000_A602;
        wr[4] = 1'b1;
        @(posedge clk);
        #1;
        wr = 6'h00;
        be = status.bus_error;
        repeat (3)
        begin
            @(posedge clk);
            #1;
            be = be | status.bus_error;
        end
        `CHK("closed window", 2'b10, {be, status.sys_reset})
        ticks(143);
        w(4, 32'h0000_A602);
        w(4, 32'h0000_B480);
        vchk("open window", 32'h0000_0100);
        c.invalid_access_reset = 1'b1;
        en(32'h0000_0100);
        w(4, 32'h0000_A602);
        repeat (2) @(posedge clk);
        #1;
        `CHK("closed reset", 1'b1, status.sys_reset)
    endtask : t_window

    initial
    begin
        repeat (16) @(posedge clk);
        #1;
        srst = 1'b0;
        t_reset();
        strap = 1'b0;
        t_floor();
        t_count();
        t_service();
        t_keyed();
        t_lock();
        t_tmo();
        t_window();
        final_report();
    end
endmodule : wkw_top_tb
